//--- rtl/psram_port_pkg.sv
// package: constants for the ddr pseudo-static memory command/address port
package psram_port_pkg;
    localparam int CMD_BYTES = 6;
    localparam int CMD_BITS = 48;
    localparam int DIR_BIT = 47;
    localparam int SPACE_BIT = 46;
    localparam int BURST_BIT = 45;
    localparam int ROW_HI = 44;
    localparam int ROW_LO = 16;
    localparam int ROW_W = 29;
    localparam int COL_W = 3;
    localparam int BURST_GROUP_WORDS = 8;
    localparam logic [2:0] CNT_RESET = 3'h0;
    localparam logic [47:0] CMD_RESET = 48'h0;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [28:0] ROW_RESET = 29'h0;
    localparam logic [2:0] COL_RESET = 3'h0;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_CMD   = 4'b0010,
        ST_READ  = 4'b0100,
        ST_WRITE = 4'b1000
    } port_state_t;
endpackage

//--- rtl/ddr_psram_cmd_addr_port.sv
// design: command/address capture and strobe control of the memory port
`timescale 1ns/1ps
module ddr_psram_cmd_addr_port
    import psram_port_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link pins; all inputs but diff_clock_en sampled through two flops
    input wire logic chip_select_n,
    input wire logic link_clock,
    input wire logic clock_complement,
    input wire logic diff_clock_en,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe,
    input wire logic bidir_data_strobe_in,
    output logic bidir_data_strobe_out,
    output logic bidir_data_strobe_oe,
    // core side status
    input wire logic refresh_pending,
    input wire logic [15:0] read_word,
    output logic cmd_valid,
    output logic cmd_read,
    output logic cmd_reg_space,
    output logic cmd_linear,
    output logic [28:0] cmd_row,
    output logic [2:0] cmd_col,
    output logic [2:0] word_ptr,
    output logic [15:0] write_word,
    output logic [1:0] write_byte_en,
    output logic write_strobe,
    output logic mem_write,
    output logic reg_write,
    output logic read_advance
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [12:0] sync1_q, sync1_d, sync2_q, sync2_d;
    logic ck_prev_q, ck_prev_d;

    always_comb begin
        sync1_d = {chip_select_n, link_clock, clock_complement,
                   bidir_data_strobe_in, dq_in, 1'b0};
        sync2_d = sync1_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 13'h1000;
            sync2_q <= 13'h1000;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    logic cs_n_s, ck_s, ckc_s, bidir_data_strobe_s, ck_lvl, ck_edge;
    logic [7:0] dq_s;
    assign cs_n_s = sync2_q[12];
    assign ck_s = sync2_q[11];
    assign ckc_s = sync2_q[10];
    assign bidir_data_strobe_s = sync2_q[9];
    assign dq_s = sync2_q[8:1];
    // differential uses the crossing, single-ended ignores complement
    assign ck_lvl = diff_clock_en ? (ck_s & ~ckc_s) : ck_s;
    assign ck_edge = ck_lvl ^ ck_prev_q;

    // ------------------------------------------------------------
    // transaction control
    // ------------------------------------------------------------
    port_state_t state_q, state_d;
    logic [2:0] cnt_q, cnt_d;
    logic [47:0] cmd_q, cmd_d;
    logic half_q, half_d;
    logic [7:0] byte_q, byte_d;
    logic mask_a_q, mask_a_d;
    logic [2:0] ptr_q, ptr_d;
    logic [7:0] dq_out_q, dq_out_d;
    logic dq_oe_q, dq_oe_d, bidir_data_strobe_q, bidir_data_strobe_d, bidir_data_strobe_oe_q, bidir_data_strobe_oe_d;
    logic valid_q, valid_d, wstb_q, wstb_d, radv_q, radv_d;
    logic mwr_q, mwr_d, rwr_q, rwr_d;
    logic [15:0] wword_q, wword_d;
    logic [1:0] ben_q, ben_d;

    // next word pointer: wrapped stays in 8-word group
    function automatic logic [2:0] next_ptr(input logic [2:0] p);
        next_ptr = p + 3'h1;
    endfunction

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        cmd_d = cmd_q;
        half_d = half_q;
        byte_d = byte_q;
        mask_a_d = mask_a_q;
        ptr_d = ptr_q;
        dq_out_d = dq_out_q;
        dq_oe_d = dq_oe_q;
        bidir_data_strobe_d = bidir_data_strobe_q;
        bidir_data_strobe_oe_d = bidir_data_strobe_oe_q;
        valid_d = 1'b0;
        wstb_d = 1'b0;
        radv_d = 1'b0;
        mwr_d = 1'b0;
        rwr_d = 1'b0;
        wword_d = wword_q;
        ben_d = ben_q;
        ck_prev_d = ck_lvl;
        unique case (state_q)
            ST_IDLE: begin
                dq_oe_d = 1'b0;
                bidir_data_strobe_oe_d = 1'b0;
                ck_prev_d = 1'b0;
                // select falls with clock idle low
                if (!cs_n_s && !ck_lvl) begin
                    state_d = ST_CMD;
                    cnt_d = CNT_RESET;
                    bidir_data_strobe_d = refresh_pending;
                    bidir_data_strobe_oe_d = 1'b1;
                end
            end
            ST_CMD: begin
                if (cs_n_s) begin
                    state_d = ST_IDLE;
                    bidir_data_strobe_oe_d = 1'b0;
                end else if (ck_edge) begin
                    // shift in msb byte first, dq7 is bit 7
                    cmd_d = {cmd_q[39:0], dq_s};
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == 3'(CMD_BYTES - 1)) begin
                        valid_d = 1'b1;
                        half_d = 1'b0;
                        ptr_d = cmd_d[COL_W-1:0];
                        if (cmd_d[DIR_BIT]) begin
                            state_d = ST_READ;
                            bidir_data_strobe_d = 1'b0;
                        end else begin
                            state_d = ST_WRITE;
                            bidir_data_strobe_oe_d = 1'b0;
                        end
                    end
                end
            end
            ST_READ: begin
                if (cs_n_s) begin
                    state_d = ST_IDLE;
                    dq_oe_d = 1'b0;
                    bidir_data_strobe_oe_d = 1'b0;
                end else if (ck_edge) begin
                    // byte A high half then byte B, strobe toggles
                    dq_oe_d = 1'b1;
                    dq_out_d = half_q ? read_word[7:0] : read_word[15:8];
                    bidir_data_strobe_d = ~half_q;
                    half_d = ~half_q;
                    if (half_q) begin
                        radv_d = 1'b1;
                        ptr_d = next_ptr(ptr_q);
                    end
                end
            end
            ST_WRITE: begin
                if (cs_n_s) begin
                    state_d = ST_IDLE;
                end else if (ck_edge) begin
                    half_d = ~half_q;
                    if (!half_q) begin
                        byte_d = dq_s;
                        mask_a_d = bidir_data_strobe_s;
                    end else begin
                        wword_d = {byte_q, dq_s};
                        ben_d = {~mask_a_q, ~bidir_data_strobe_s};
                        wstb_d = 1'b1;
                        mwr_d = ~cmd_q[SPACE_BIT];
                        rwr_d = cmd_q[SPACE_BIT];
                        ptr_d = next_ptr(ptr_q);
                    end
                end
            end
        endcase
    end

    // reset floats strobe and data, returns to standby
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= CNT_RESET;
            cmd_q <= CMD_RESET;
            half_q <= 1'b0;
            byte_q <= BYTE_RESET;
            mask_a_q <= 1'b1;
            ptr_q <= COL_RESET;
            dq_out_q <= BYTE_RESET;
            dq_oe_q <= 1'b0;
            bidir_data_strobe_q <= 1'b0;
            bidir_data_strobe_oe_q <= 1'b0;
            valid_q <= 1'b0;
            wstb_q <= 1'b0;
            radv_q <= 1'b0;
            mwr_q <= 1'b0;
            rwr_q <= 1'b0;
            wword_q <= WORD_RESET;
            ben_q <= 2'h0;
            ck_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            cmd_q <= cmd_d;
            half_q <= half_d;
            byte_q <= byte_d;
            mask_a_q <= mask_a_d;
            ptr_q <= ptr_d;
            dq_out_q <= dq_out_d;
            dq_oe_q <= dq_oe_d;
            bidir_data_strobe_q <= bidir_data_strobe_d;
            bidir_data_strobe_oe_q <= bidir_data_strobe_oe_d;
            valid_q <= valid_d;
            wstb_q <= wstb_d;
            radv_q <= radv_d;
            mwr_q <= mwr_d;
            rwr_q <= rwr_d;
            wword_q <= wword_d;
            ben_q <= ben_d;
            ck_prev_q <= ck_prev_d;
        end
    end

    // ------------------------------------------------------------
    // outputs from flops; bits 15..3 of the command are ignored
    // ------------------------------------------------------------
    assign dq_out = dq_out_q;
    assign dq_oe = dq_oe_q;
    assign bidir_data_strobe_out = bidir_data_strobe_q;
    assign bidir_data_strobe_oe = bidir_data_strobe_oe_q;
    assign cmd_valid = valid_q;
    assign cmd_read = cmd_q[DIR_BIT];
    assign cmd_reg_space = cmd_q[SPACE_BIT];
    assign cmd_linear = cmd_q[BURST_BIT];
    assign cmd_row = cmd_q[ROW_HI:ROW_LO];
    assign cmd_col = cmd_q[COL_W-1:0];
    assign word_ptr = ptr_q;
    assign write_word = wword_q;
    assign write_byte_en = ben_q;
    assign write_strobe = wstb_q;
    assign mem_write = mwr_q;
    assign reg_write = rwr_q;
    assign read_advance = radv_q;
endmodule

//--- test/psram_port_assertions.sv
// checker: port assertions for the memory command/address port
`timescale 1ns/1ps
module psram_port_assertions
    import psram_port_pkg::*;
(
    // ----------------------------------------
    // watched ports
    // ----------------------------------------
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire logic bidir_data_strobe_oe,
    input wire logic dq_oe,
    input wire logic cmd_valid,
    input wire logic cmd_read,
    input wire logic cmd_reg_space,
    input wire logic [28:0] cmd_row,
    input wire logic write_strobe,
    input wire logic mem_write,
    input wire logic reg_write,
    input wire logic read_advance
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    release_oe_a: assert property (chip_select_n [*5] |->
        !bidir_data_strobe_oe && !dq_oe) else $error("driven while idle");
    fields_hold_a: assert property (cmd_valid |=> (!cmd_valid &&
        $stable(cmd_row) && $stable(cmd_read)) [*3]) else $error("cmd moved");
    write_gap_a: assert property (write_strobe |=> !write_strobe [*3])
        else $error("write words too close");
    mem_write_a: assert property (mem_write |-> write_strobe &&
        !cmd_reg_space && !cmd_read) else $error("bad memory write");
    reg_write_a: assert property (reg_write |-> write_strobe &&
        cmd_reg_space) else $error("bad register write");
    dq_read_a: assert property (dq_oe |-> cmd_read)
        else $error("data driven on write");
    read_adv_a: assert property (read_advance |-> cmd_read &&
        !write_strobe) else $error("bad read advance");
    reset_float_a: assert property ($rose(rst_n) |->
        !bidir_data_strobe_oe && !dq_oe) else $error("driven in reset");
endmodule

bind ddr_psram_cmd_addr_port psram_port_assertions u_chk (.clk(clk),
    .rst_n(rst_n), .chip_select_n(chip_select_n), .dq_oe(dq_oe),
    .bidir_data_strobe_oe(bidir_data_strobe_oe), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .cmd_reg_space(cmd_reg_space), .cmd_row(cmd_row),
    .write_strobe(write_strobe), .mem_write(mem_write),
    .reg_write(reg_write), .read_advance(read_advance));

//--- test/host_model.sv
// partner: host controller driving select, link clock and data
`timescale 1ns/1ps
module host_model (
    // ----------------------------------------
    // host driven link pins
    // ----------------------------------------
    output logic chip_select_n,
    output logic link_clock,
    output logic clock_complement,
    output logic [7:0] dq_in,
    output logic strobe_drive,
    output logic strobe_en
);
    initial begin
        {chip_select_n, link_clock, clock_complement} = 3'h5;
        {dq_in, strobe_drive, strobe_en} = 10'h000;
    end
    // mask holds strobe levels for bytes a and b, high masks
    task automatic txn(input logic [47:0] ca, input int nca,
        input logic [15:0] wd, input logic [1:0] mask, input int nd);
        #7 chip_select_n = 1'b0;
        // data moves mid-way between clock edges, centred on each edge
        for (int i = 0; i < nca + nd; i++) begin
            #20 dq_in = (i < 6) ? ca[47 - 8 * (i % 6) -: 8] :
                (i == 6) ? wd[15:8] : wd[7:0];
            strobe_en = (i >= 6);
            strobe_drive = (i == 6) ? mask[1] : mask[0];
            #20 link_clock = ~link_clock;
            clock_complement = ~link_clock;
        end
        #40 chip_select_n = 1'b1;
        dq_in = ~dq_in;
        strobe_en = 1'b0;
        #80 link_clock = 1'b0;
        clock_complement = 1'b1;
    endtask
endmodule

//--- test/tb_top.sv
// testbench: random and corner transactions through the memory port
`timescale 1ns/1ps
module tb_top;
    import psram_port_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, diff_clock_en = 1'b0;
    logic refresh_pending = 1'b0;
    logic [15:0] read_word = 16'h0000;
    logic chip_select_n, link_clock, clock_complement, strobe_drive, strobe_en;
    logic [7:0] dq_in, dq_out;
    logic dq_oe, strobe_out, strobe_oe, strobe_wire, cmd_valid, cmd_read;
    logic cmd_reg_space, cmd_linear, write_strobe, mem_write, reg_write;
    logic read_advance, got_lat, got_mem;
    logic [28:0] cmd_row;
    logic [2:0] cmd_col, word_ptr;
    logic [15:0] write_word, got_wd;
    logic [1:0] write_byte_en, got_en;
    logic [47:0] got_ca;
    logic [7:0] got_rd;
    logic oe_prev = 1'b0, dq_prev = 1'b0;
    int miscompares = 0, tests_run = 0, n_valid = 0, n_wr = 0, n_rd = 0;
    always #5 clk = ~clk;
    assign strobe_wire = strobe_oe ? strobe_out :
        strobe_en ? strobe_drive : ~strobe_out;
    host_model u_host (.chip_select_n(chip_select_n), .dq_in(dq_in),
        .link_clock(link_clock), .clock_complement(clock_complement),
        .strobe_drive(strobe_drive), .strobe_en(strobe_en));
    ddr_psram_cmd_addr_port u_dut (.clk(clk), .rst_n(rst_n),
        .chip_select_n(chip_select_n), .link_clock(link_clock),
        .clock_complement(clock_complement), .diff_clock_en(diff_clock_en),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .bidir_data_strobe_in(strobe_wire), .bidir_data_strobe_out(strobe_out),
        .bidir_data_strobe_oe(strobe_oe), .refresh_pending(refresh_pending),
        .read_word(read_word), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
        .cmd_reg_space(cmd_reg_space), .cmd_linear(cmd_linear),
        .cmd_row(cmd_row), .cmd_col(cmd_col), .word_ptr(word_ptr),
        .write_word(write_word), .write_byte_en(write_byte_en),
        .write_strobe(write_strobe), .mem_write(mem_write),
        .reg_write(reg_write), .read_advance(read_advance));
    // ----------------------------------------
    // monitor and helpers
    // ----------------------------------------
    always @(negedge clk) begin
        if (cmd_valid) begin
            got_ca = {cmd_read, cmd_reg_space, cmd_linear, cmd_row,
                13'h0000, cmd_col};
            n_valid++;
        end
        if (write_strobe) begin
            {got_wd, got_en, got_mem} = {write_word, write_byte_en, mem_write};
            n_wr++;
        end
        if (read_advance) n_rd++;
        // latency flag is the strobe level as it is first driven
        if (strobe_oe && !oe_prev) got_lat = strobe_out;
        if (dq_oe && !dq_prev) got_rd = dq_out;
        {oe_prev, dq_prev} = {strobe_oe, dq_oe};
    end
    function automatic logic [47:0] expect_ca(input logic [47:0] ca);
        return {ca[47:16], 13'h0000, ca[2:0]};
    endfunction
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic run(input logic [47:0] ca, input int nca,
        input logic [1:0] mask);
        int v, w, r;
        logic [15:0] wd;
        {v, w, r} = {n_valid, n_wr, n_rd};
        wd = 16'($urandom);
        @(posedge clk);
        refresh_pending <= 1'($urandom);
        diff_clock_en <= 1'($urandom);
        read_word <= 16'($urandom);
        @(posedge clk);
        u_host.txn(ca, nca, wd, mask, (nca == 6) ? 2 : 0);
        repeat (6) @(posedge clk);
        cmp(n_valid - v, nca == 6);
        if (nca == 6) begin
            cmp(got_ca, expect_ca(ca));
            cmp(got_lat, refresh_pending);
            cmp(n_wr - w, !ca[47]);
            cmp(n_rd - r, ca[47]);
        end
        if (nca == 6 && !ca[47])
            cmp({got_wd, got_en, got_mem}, {wd, ~mask, !ca[46]});
        if (nca == 6 && ca[47])
            cmp(got_rd, read_word[15:8]);
        cmp({strobe_oe, dq_oe}, 2'h0);
        $display("test done ca %h parts %0d", ca, nca);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [47:0] ca;
        int v;
        void'($urandom(18));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int k = 0; k < 16; k++) begin
            ca = {k[2:0], 29'($urandom), 13'h0000, 3'($urandom)};
            run(ca, 6, 2'($urandom));
        end
        run(48'h1FFF_FFFF_FFFF, 6, 2'b11);
        run(48'hBFFF_FFFF_0007, 3, 2'b00);
        v = n_valid;
        fork
            u_host.txn(48'h0, 6, 16'hA55A, 2'b00, 2);
            begin
                repeat (15) @(posedge clk);
                rst_n <= 1'b0;
                @(negedge clk);
                cmp({strobe_oe, dq_oe, cmd_valid}, 3'h0);
            end
        join
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        cmp(n_valid - v, 0);
        $display("test done reset in command");
        report_and_stop;
    end
    initial begin
        #100000;
        miscompares++;
        report_and_stop;
    end
endmodule
